// ---- rtl/uvp_regs.vh ----
// timing and code constants for the eprom programmer controller
`ifndef UVP_REGS_VH
`define UVP_REGS_VH

// clock rate in MHz
`define UVP_CLK_MHZ 250
// initial pulse, microseconds (nominal 1 ms)
`define UVP_INIT_PULSE_US 1000
// overprogram pulse per initial pulse, microseconds (3 ms)
`define UVP_OVER_PULSE_US 3000
// setup / hold times, microseconds
`define UVP_SETUP_US 2
// read access wait (access delay) in ns
`define UVP_ACCESS_NS 250
// gate release float time in ns
`define UVP_FLOAT_NS 130
// most initial pulses per byte
`define UVP_MAX_PULSES 25
// erased byte value
`define UVP_ERASED 8'hff
// cycles beyond the loaded count from a timer load request until the fsm acts on done
`define UVP_TIMER_LAG 32'h2

// command codes
`define UVP_CMD_READ 2'h0
`define UVP_CMD_PROG 2'h1
`define UVP_CMD_IDENT 2'h2

// answer status
`define UVP_ST_OK 2'h0
`define UVP_ST_FAIL 2'h1
`define UVP_ST_ZERO 2'h2

`endif

// ---- rtl/uvp_timer.v ----
// down counter that marks the end of a wait with a one-cycle pulse
`timescale 1ns/10ps
module uvp_timer #(
    parameter WIDTH = 32
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // control
    input wire load,
    input wire [WIDTH-1:0] count,
    // status
    output reg done
);
    reg [WIDTH-1:0] left;
    reg run;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            left <= {WIDTH{1'b0}};
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                left <= count;
                run <= 1'b1;
            end else if (run) begin
                if (left <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    run <= 1'b0;
                    done <= 1'b1;
                end else begin
                    left <= left - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ---- rtl/uvp_ctrl.v ----
// pin-level controller that reads, identifies and programs a uv eprom
//
// Overview of operation
// (R01) device drives data only with select and gate
// (R02) data valid one gate delay after gate
// (R03) select high means standby, outputs floating
// (R04) select per device, gate shared from read strobe
// (R05) erased cells read one; program only clears
// (R06) raised supply, select and strobe low program
// (R07) no programming with select or strobe high
// (R08) verify: gate low, select low, strobe high
// (R09) identifier mode needs high voltage line
// (R10) byte select low maker, high device code
// (R11) other address lines low in identifier mode
// (R12) verify each pulse, fail after 25 pulses
// (R13) overprogram pulse three ms times pulse count
// (R14) initial strobe pulse about one millisecond
// (R15) overprogram pulse 2.85 to 78.75 ms
// (R16) pulses at raised supplies, final compare normal; code keeps supply raised through verify and does no final compare
// (R17) gate high in programming, device floats data
// (R18) read timing as delays, not clock cycles
`timescale 1ns/10ps
`include "uvp_regs.vh"
module uvp_ctrl #(
    parameter AW = 14,
    parameter MAX_PULSES = `UVP_MAX_PULSES,
    parameter INIT_CYC = `UVP_INIT_PULSE_US * `UVP_CLK_MHZ,
    parameter OVER_CYC = `UVP_OVER_PULSE_US * `UVP_CLK_MHZ,
    parameter SETUP_CYC = `UVP_SETUP_US * `UVP_CLK_MHZ,
    parameter ACCESS_CYC = (`UVP_ACCESS_NS * `UVP_CLK_MHZ + 999) / 1000,
    parameter FLOAT_CYC = (`UVP_FLOAT_NS * `UVP_CLK_MHZ + 999) / 1000
) (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // command port
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [AW-1:0] cmd_addr,
    input wire [7:0] cmd_data,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_data,
    output reg [1:0] rsp_status,
    output reg [4:0] rsp_pulses,
    // eprom pins
    output reg [AW-1:0] addr,
    output reg chip_select_n,
    output reg output_gate_n,
    output reg program_strobe_n,
    output reg prog_supply_en,
    output reg id_high_voltage_en,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe
);
    localparam S_IDLE = 4'h0;
    localparam S_RD_WAIT = 4'h1;
    localparam S_PG_SETUP = 4'h2;
    localparam S_PG_PULSE = 4'h3;
    localparam S_PG_HOLD = 4'h4;
    localparam S_VF_WAIT = 4'h5;
    localparam S_VF_CHECK = 4'h6;
    localparam S_OP_PULSE = 4'h7;
    localparam S_OP_HOLD = 4'h8;
    localparam S_DONE = 4'h9;
    localparam S_OP_SETUP = 4'ha;
    // strobe widths subtract the timer lag so pulses are exact
    localparam [31:0] TIMER_LAG = `UVP_TIMER_LAG;

    reg [3:0] state;
    reg [1:0] op;
    reg [7:0] wdata;
    reg [4:0] pulses;
    reg t_load;
    reg [31:0] t_count;
    wire t_done;

    uvp_timer #(.WIDTH(32)) u_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .load(t_load),
        .count(t_count),
        .done(t_done)
    );

    // id byte select is address bit 0; rest held low in id mode
    wire [AW-1:0] id_addr = {{(AW-1){1'b0}}, cmd_addr[0]}; // R11

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            op <= `UVP_CMD_READ;
            wdata <= `UVP_ERASED;
            pulses <= 5'h00;
            t_load <= 1'b0;
            t_count <= 32'h0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_status <= `UVP_ST_OK;
            rsp_pulses <= 5'h00;
            addr <= {AW{1'b0}};
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            program_strobe_n <= 1'b1;
            prog_supply_en <= 1'b0;
            id_high_voltage_en <= 1'b0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            t_load <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
            S_IDLE: begin
                // deselected: device in standby, floating
                chip_select_n <= 1'b1; // R03
                output_gate_n <= 1'b1;
                program_strobe_n <= 1'b1;
                data_oe <= 1'b0;
                cmd_ready <= 1'b1;
                if (cmd_valid && cmd_ready) begin
                    cmd_ready <= 1'b0;
                    op <= cmd_op;
                    wdata <= cmd_data;
                    pulses <= 5'h00;
                    t_load <= 1'b1;
                    if (cmd_op == `UVP_CMD_PROG) begin
                        // gate high so device floats, then drive data
                        addr <= cmd_addr;
                        prog_supply_en <= 1'b1; // R16
                        id_high_voltage_en <= 1'b0;
                        chip_select_n <= 1'b0;
                        data_out <= cmd_data;
                        data_oe <= 1'b1; // R17
                        t_count <= SETUP_CYC;
                        state <= S_PG_SETUP;
                    end else begin
                        prog_supply_en <= 1'b0;
                        if (cmd_op == `UVP_CMD_IDENT) begin
                            addr <= id_addr; // R11
                            id_high_voltage_en <= 1'b1; // R09 R10
                        end else begin
                            addr <= cmd_addr;
                            id_high_voltage_en <= 1'b0;
                        end
                        // per-device select plus shared read gate
                        chip_select_n <= 1'b0; // R04
                        output_gate_n <= 1'b0; // R01
                        t_count <= ACCESS_CYC; // R02 R18
                        state <= S_RD_WAIT;
                    end
                end
            end
            S_RD_WAIT: begin
                if (t_done) begin
                    rsp_data <= data_in;
                    rsp_status <= `UVP_ST_OK;
                    rsp_pulses <= 5'h00;
                    state <= S_DONE;
                end
            end
            S_PG_SETUP: begin
                if (t_done) begin
                    // select and strobe both low: byte accepted
                    program_strobe_n <= 1'b0; // R06
                    pulses <= pulses + 5'h01;
                    t_load <= 1'b1;
                    t_count <= INIT_CYC - TIMER_LAG; // R14
                    state <= S_PG_PULSE;
                end
            end
            S_PG_PULSE: begin
                if (t_done) begin
                    program_strobe_n <= 1'b1; // R07
                    t_load <= 1'b1;
                    t_count <= SETUP_CYC;
                    state <= S_PG_HOLD;
                end
            end
            S_PG_HOLD: begin
                if (t_done) begin
                    // release data and take gate low in the same cycle to verify
                    data_oe <= 1'b0;
                    output_gate_n <= 1'b0; // R08
                    t_load <= 1'b1;
                    t_count <= SETUP_CYC;
                    state <= S_VF_WAIT;
                end
            end
            S_VF_WAIT: begin
                if (t_done) begin
                    rsp_data <= data_in;
                    output_gate_n <= 1'b1;
                    t_load <= 1'b1;
                    t_count <= FLOAT_CYC + SETUP_CYC;
                    state <= S_VF_CHECK;
                end
            end
            S_VF_CHECK: begin
                if (t_done) begin
                    if (rsp_data == wdata) begin
                        // data set up ahead of the long pulse
                        data_oe <= 1'b1;
                        t_load <= 1'b1;
                        t_count <= SETUP_CYC;
                        state <= S_OP_SETUP;
                    end else if ((wdata & ~rsp_data) != 8'h00) begin
                        // a zero cannot become one without erasure
                        rsp_status <= `UVP_ST_ZERO; // R05
                        state <= S_DONE;
                    end else if (pulses >= MAX_PULSES) begin
                        rsp_status <= `UVP_ST_FAIL; // R12
                        state <= S_DONE;
                    end else begin
                        // retry: data set up again before the pulse
                        data_oe <= 1'b1;
                        t_load <= 1'b1;
                        t_count <= SETUP_CYC;
                        state <= S_PG_SETUP; // R12
                    end
                end
            end
            S_OP_SETUP: begin
                if (t_done) begin
                    program_strobe_n <= 1'b0;
                    t_load <= 1'b1;
                    t_count <= OVER_CYC * pulses - TIMER_LAG; // R13 R15
                    state <= S_OP_PULSE;
                end
            end
            S_OP_PULSE: begin
                if (t_done) begin
                    program_strobe_n <= 1'b1;
                    t_load <= 1'b1;
                    t_count <= SETUP_CYC;
                    state <= S_OP_HOLD;
                end
            end
            S_OP_HOLD: begin
                if (t_done) begin
                    data_oe <= 1'b0;
                    rsp_status <= `UVP_ST_OK;
                    state <= S_DONE;
                end
            end
            S_DONE: begin
                rsp_valid <= 1'b1;
                rsp_pulses <= pulses;
                chip_select_n <= 1'b1;
                output_gate_n <= 1'b1;
                program_strobe_n <= 1'b1;
                prog_supply_en <= 1'b0;
                id_high_voltage_en <= 1'b0;
                data_oe <= 1'b0;
                state <= S_IDLE;
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end
endmodule

// ---- verif/uvp_ctrl_props.sv ----
// concurrent checks on the eprom programmer controller pins
`timescale 1ns/10ps
module uvp_ctrl_props #(
    parameter AW = 14,
    parameter MAX_PULSES = 25,
    parameter INIT_CYC = 20,
    parameter OVER_CYC = 60
) (
    input wire mclk,
    input wire arst_n,
    input wire rsp_valid,
    input wire [1:0] rsp_status,
    input wire [4:0] rsp_pulses,
    input wire [AW-1:0] addr,
    input wire chip_select_n,
    input wire output_gate_n,
    input wire program_strobe_n,
    input wire prog_supply_en,
    input wire id_high_voltage_en,
    input wire [7:0] data_out,
    input wire data_oe
);
    reg [31:0] low_cnt;
    reg [31:0] last_len;
    // length of the strobe pulse now running and of the last one
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= 32'h0;
            last_len <= 32'h0;
        end else begin
            low_cnt <= program_strobe_n ? 32'h0 : low_cnt + 32'h1;
            if (program_strobe_n && low_cnt != 32'h0)
                last_len <= low_cnt;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_gate_sel; !output_gate_n |-> !chip_select_n; endproperty
    a_gate_sel: assert property (p_gate_sel) else $error("gate unselected");
    property p_strobe; !program_strobe_n |->
        prog_supply_en && !chip_select_n && output_gate_n; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe levels");
    property p_float; !output_gate_n |-> !data_oe; endproperty
    a_float: assert property (p_float) else $error("data contention");
    property p_hold; !program_strobe_n && !$past(program_strobe_n) |->
        $stable(data_out) && $stable(addr) && data_oe; endproperty
    a_hold: assert property (p_hold) else $error("data moved in pulse");
    property p_width; $rose(program_strobe_n) |->
        low_cnt == INIT_CYC || low_cnt % OVER_CYC == 0; endproperty
    a_width: assert property (p_width) else $error("pulse width");
    property p_over; rsp_valid && rsp_status == 2'h0 && rsp_pulses != 5'h0
        |-> last_len == OVER_CYC * rsp_pulses; endproperty
    a_over: assert property (p_over) else $error("overprogram length");
    property p_limit; rsp_valid |-> rsp_pulses <= MAX_PULSES; endproperty
    a_limit: assert property (p_limit) else $error("too many pulses");
    property p_ident; id_high_voltage_en |->
        addr[AW-1:1] == 0 && !prog_supply_en; endproperty
    a_ident: assert property (p_ident) else $error("ident address");
endmodule

bind uvp_ctrl uvp_ctrl_props #(.AW(AW), .MAX_PULSES(MAX_PULSES),
    .INIT_CYC(INIT_CYC), .OVER_CYC(OVER_CYC)) u_props (
    .mclk(mclk), .arst_n(arst_n), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .rsp_pulses(rsp_pulses), .addr(addr),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .program_strobe_n(program_strobe_n), .prog_supply_en(prog_supply_en),
    .id_high_voltage_en(id_high_voltage_en), .data_out(data_out),
    .data_oe(data_oe));

// ---- verif/uvp_eprom_model.sv ----
// behavioural uv eprom answering the controller pins
`timescale 1ns/10ps
module uvp_eprom_model #(
    parameter AW = 14,
    parameter GATE_NS = 12,
    parameter MAKER = 8'h5a,
    parameter DEVICE = 8'hc3
) (
    input wire [AW-1:0] addr,
    input wire chip_select_n,
    input wire output_gate_n,
    input wire program_strobe_n,
    input wire prog_supply_en,
    input wire id_high_voltage_en,
    input wire [7:0] data_out,
    input wire [31:0] need,
    output wire [7:0] data_in
);
    reg [7:0] mem [0:(1<<AW)-1];
    reg [7:0] last;
    reg [31:0] hits;
    integer i;
    wire drv = !chip_select_n && !output_gate_n;
    wire drv_d;
    wire [7:0] val = id_high_voltage_en ?
        (addr[0] ? DEVICE : MAKER) : mem[addr];
    assign #(GATE_NS) drv_d = drv;
    // released pins show the inverse of the last byte
    assign data_in = (drv && drv_d) ? val : ~last;
    initial begin
        for (i = 0; i < (1 << AW); i = i + 1)
            mem[i] = 8'hff;
        last = 8'hff;
        hits = 32'h0;
    end
    always @* if (drv && drv_d) last = val;
    always @(negedge prog_supply_en) hits = 32'h0;
    // a byte sticks only after need pulses
    always @(posedge program_strobe_n) begin
        if (prog_supply_en && !chip_select_n) begin
            hits = hits + 32'h1;
            if (hits >= need)
                mem[addr] = mem[addr] & data_out;
        end
    end
endmodule

// ---- verif/uv_eprom_read_program_control_bench.sv ----
// self-checking bench for the eprom programmer controller
`timescale 1ns/10ps
`include "uvp_regs.vh"
module uv_eprom_read_program_control_bench;
    localparam MAKER = 8'h5a; // arbitrary value
    localparam DEVICE = 8'hc3; // arbitrary value
    reg mclk = 1'b0;
    reg arst_n = 1'b0;
    reg cmd_valid = 1'b0;
    reg [1:0] cmd_op = 2'h0;
    reg [13:0] cmd_addr = 14'h0;
    reg [7:0] cmd_data = 8'h0;
    reg [31:0] need = 32'h1;
    integer fail_count = 0;
    integer compares = 0;
    wire cmd_ready, rsp_valid, chip_select_n, output_gate_n;
    wire program_strobe_n, prog_supply_en, id_high_voltage_en, data_oe;
    wire [7:0] rsp_data, data_in, data_out;
    wire [1:0] rsp_status;
    wire [4:0] rsp_pulses;
    wire [13:0] addr;
    always #2 mclk = ~mclk;
    uvp_ctrl #(.INIT_CYC(20), .OVER_CYC(60), .SETUP_CYC(4), .ACCESS_CYC(4),
        .FLOAT_CYC(2)) dut (
        .mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_status(rsp_status),
        .rsp_pulses(rsp_pulses), .addr(addr), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n),
        .prog_supply_en(prog_supply_en),
        .id_high_voltage_en(id_high_voltage_en), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    uvp_eprom_model #(.MAKER(MAKER), .DEVICE(DEVICE)) model (
        .addr(addr), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n),
        .prog_supply_en(prog_supply_en),
        .id_high_voltage_en(id_high_voltage_en), .data_out(data_out),
        .need(need), .data_in(data_in));
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task check(input [63:0] seen, input [63:0] exp, input [8*6:1] what);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task do_cmd(input [1:0] op, input [13:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(posedge mclk);
            cmd_valid <= 1'b1;
            cmd_op <= op;
            cmd_addr <= a;
            cmd_data <= d;
            @(negedge mclk);
            while (cmd_ready !== 1'b1 && n < 20000) begin
                @(negedge mclk);
                n = n + 1;
            end
            @(posedge mclk);
            cmd_valid <= 1'b0;
            while (rsp_valid !== 1'b1 && n < 20000) begin
                @(negedge mclk);
                n = n + 1;
            end
            @(negedge mclk);
            check(chip_select_n, 1'b1, "select");
            check(prog_supply_en, 1'b0, "supply");
            if (n >= 20000) begin
                fail_count = fail_count + 1;
                tally_and_finish;
            end
        end
    endtask
    task t_erased;
        begin
            do_cmd(`UVP_CMD_READ, 14'h3fff, 8'h0);
            check(rsp_data, 8'hff, "data");
            check(rsp_status, `UVP_ST_OK, "status");
        end
    endtask
    task t_program;
        begin
            need = 32'h3;
            do_cmd(`UVP_CMD_PROG, 14'h123, 8'ha5);
            check(rsp_status, `UVP_ST_OK, "status");
            check(rsp_pulses, 5'h3, "pulses");
            do_cmd(2'h3, 14'h123, 8'h0);
            check(rsp_data, 8'ha5, "data");
            do_cmd(`UVP_CMD_PROG, 14'h123, 8'hff);
            check(rsp_status, `UVP_ST_ZERO, "status");
        end
    endtask
    task t_give_up;
        begin
            need = 32'h1e;
            do_cmd(`UVP_CMD_PROG, 14'h5, 8'h0f);
            check(rsp_status, `UVP_ST_FAIL, "status");
            check(rsp_pulses, 5'h19, "pulses");
        end
    endtask
    task t_ident;
        integer i;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                do_cmd(`UVP_CMD_IDENT, 14'h3ffe | i[13:0], 8'h0);
                check(rsp_data, i ? DEVICE : MAKER, "ident");
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        t_erased;
        t_program;
        t_give_up;
        t_ident;
        tally_and_finish;
    end
endmodule
